// File: hw/clk_div_if.sv
// Link between the mode controller and the system clock prescaler.
// Assumes both ends share pclk.
`timescale 1ns/1ps
interface clk_div_if;
  logic [1:0] divider;
  logic run;
  logic tick;
  modport ctrl (output divider, output run, input tick);
  modport divider_end (input divider, input run, output tick);
endinterface : clk_div_if

// File: hw/power_mode_clock_control.sv
// Operating mode and system clock controller with APB registers.
// Assumes one 10 MHz clock, asynchronous pins and same-clock event pulses.
// What this block does
// RQ1 - Fast select runs core on fast clock.
// RQ2 - Idle request bit enters Idle.
// RQ3 - Idle stops core, peripherals keep clock.
// RQ4 - Peripheral gate leaves only Timer3 and pins.
// RQ5 - Idle ends on any enabled interrupt.
// RQ6 - Power-down enters Stop or Halt.
// RQ7 - Stop keeps only an enabled watchdog.
// RQ8 - Stop ends only on pin or Port1 wake.
// RQ9 - Halt keeps enabled Timer3 and watchdog.
// RQ10 - Halt ends on pin, Port1 or Timer3.
// RQ11 - No Stop while enabled pin low.
// RQ12 - Divider code sets system clock ratio.
// RQ13 - Idle wakes on any, Stop on pins and Port1.
// RQ14 - Events set flags regardless of enable.
// RQ15 - Stop wake sources are pins and Port1.
// RQ16 - Software changes slow type in Fast.
// RQ17 - Software changes fast type in Slow.
// RQ18 - Fast stop bit writable only in Slow.
// RQ19 - Source select locked while fast stopped.
// RQ20 - Wake clears idle and power-down bits.
`timescale 1ns/1ps
module power_mode_clock_control
  import power_mode_clock_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] ext_int_n,
  input wire logic [7:0] port1_pin,
  input wire logic [NUM_SRC-1:0] periph_event,
  input wire logic wdt_enable,
  input wire logic timer3_enable,
  output logic cpu_clock_on,
  output logic periph_clock_on,
  output logic timer3_clock_on,
  output logic wdt_clock_on,
  output logic fast_osc_on,
  output logic slow_osc_on,
  output logic fast_clock_selected,
  output logic fast_osc_type,
  output logic slow_osc_type,
  output logic sys_clk_tick,
  output logic irq_pending,
  output logic wake_pulse,
  output logic bandgap_output_enable
);

  clk_div_if dv ();

  power_mode_t mode_r, mode_nxt;
  logic [7:0] pmc_r, pmc_nxt;
  logic [7:0] csc_r, csc_nxt;
  logic [7:0] auxiliary_control_two_r, auxiliary_control_two_nxt;
  logic [31:0] irq_en_r, irq_en_nxt;
  logic [NUM_SRC-1:0] flag_r, flag_nxt;
  logic [10:0] sync1_r, sync2_r, prev_r;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  logic cpu_on_nxt, periph_on_nxt, t3_on_nxt, wdt_on_nxt;
  logic fast_on_nxt, slow_on_nxt, irq_nxt, wake_nxt;
  logic [NUM_SRC-1:0] event_in, enabled;
  logic [2:0] pin_low, pin_fall;
  logic [7:0] p1_change;
  logic wr, setup, pmc_wr, stop_refused, idle_wake, stop_wake, halt_wake;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] target);
    reg_hit = (addr == target);
  endfunction : reg_hit

  system_clock_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .dv(dv.divider_end)
  );

  assign dv.divider = csc_r[CSC_DIV_LSB +: 2]; // RQ12
  assign dv.run = (mode_r == MODE_RUN) || (mode_r == MODE_IDLE);
  assign sys_clk_tick = dv.tick;
  assign pready = 1'b1;
  assign fast_clock_selected = csc_r[CSC_FAST_SEL_BIT]; // RQ1
  assign fast_osc_type = csc_r[CSC_FAST_TYPE_BIT];
  assign slow_osc_type = csc_r[CSC_SLOW_TYPE_BIT];
  assign bandgap_output_enable = auxiliary_control_two_r[AUXILIARY_CONTROL_TWO_BANDGAP_BIT];

  // Pins pass two flops; only the second stage and its delayed copy are read.
  always_comb
  begin
    pin_low = ~sync2_r[2:0];
    pin_fall = prev_r[2:0] & ~sync2_r[2:0];
    p1_change = (sync2_r[10:3] ^ prev_r[10:3])
      & irq_en_r[P1_MASK_LSB +: 8];
    event_in = periph_event;
    event_in[SRC_INT0] = pin_fall[0];
    event_in[SRC_INT1] = pin_fall[1];
    event_in[SRC_INT2] = pin_fall[2];
    event_in[SRC_PORT1] = |p1_change;
  end

  always_comb
  begin
    wr = psel && penable && pwrite;
    setup = psel && !penable;
    pmc_wr = wr && reg_hit(paddr, PMC_ADDR) && (mode_r == MODE_RUN);
    enabled = flag_r & irq_en_r[NUM_SRC-1:0];
    idle_wake = |enabled; // RQ5 RQ13
    stop_wake = enabled[SRC_INT0] || enabled[SRC_INT1] // RQ15
      || enabled[SRC_INT2] || flag_r[SRC_PORT1];
    halt_wake = stop_wake || enabled[SRC_TIMER3]; // RQ10
    stop_refused = |(pin_low & {irq_en_r[SRC_INT2], // RQ11
      irq_en_r[SRC_INT1], irq_en_r[SRC_INT0]});
  end

  // Set wins over a write-one clear in the same cycle.
  for (genvar i = 0; i < NUM_SRC; i++)
  begin : g_flag
    always_comb
    begin
      flag_nxt[i] = event_in[i] // RQ14
        || (flag_r[i] && !(wr && reg_hit(paddr, IRQ_FLAG_ADDR)
        && pwdata[i]));
    end
  end

  always_comb
  begin
    mode_nxt = mode_r;
    pmc_nxt = pmc_r;
    csc_nxt = csc_r;
    auxiliary_control_two_nxt = auxiliary_control_two_r;
    irq_en_nxt = irq_en_r;
    if (pmc_wr)
    begin
      pmc_nxt = pwdata[7:0] & PMC_WMASK;
      if (pwdata[PMC_PD_BIT])
      begin
        if (!csc_r[CSC_SLOW_STOP_BIT])
          mode_nxt = MODE_HALT; // RQ6 RQ9
        else if (stop_refused)
          pmc_nxt[PMC_PD_BIT] = 1'b0; // RQ11
        else
          mode_nxt = MODE_STOP; // RQ6 RQ7
        pmc_nxt[PMC_IDLE_BIT] = 1'b0;
      end
      else if (pwdata[PMC_IDLE_BIT])
        mode_nxt = MODE_IDLE; // RQ2
    end
    case (mode_r)
      MODE_RUN: ;
      MODE_IDLE:
        if (idle_wake)
          mode_nxt = MODE_RUN; // RQ5
      MODE_STOP:
        if (stop_wake)
          mode_nxt = MODE_RUN; // RQ8
      MODE_HALT:
        if (halt_wake)
          mode_nxt = MODE_RUN; // RQ10
      default:
        mode_nxt = MODE_RUN;
    endcase
    if (mode_r != MODE_RUN && mode_nxt == MODE_RUN)
      pmc_nxt[PMC_PD_BIT:PMC_IDLE_BIT] = 2'h0; // RQ20
    if (wr && reg_hit(paddr, CSC_ADDR))
    begin
      // Type bits are stored as written; software keeps to the right mode.
      csc_nxt[CSC_SLOW_TYPE_BIT] = pwdata[CSC_SLOW_TYPE_BIT]; // RQ16
      csc_nxt[CSC_FAST_TYPE_BIT] = pwdata[CSC_FAST_TYPE_BIT]; // RQ17
      csc_nxt[CSC_SLOW_STOP_BIT] = pwdata[CSC_SLOW_STOP_BIT];
      csc_nxt[CSC_PERIPH_GATE_BIT] = pwdata[CSC_PERIPH_GATE_BIT];
      if (!csc_r[CSC_FAST_SEL_BIT])
        csc_nxt[CSC_FAST_STOP_BIT] = pwdata[CSC_FAST_STOP_BIT]; // RQ18
      if (!csc_r[CSC_FAST_STOP_BIT])
        csc_nxt[CSC_FAST_SEL_BIT] = pwdata[CSC_FAST_SEL_BIT]; // RQ19
      csc_nxt[CSC_DIV_LSB +: 2] = pwdata[CSC_DIV_LSB +: 2]; // RQ12
    end
    if (wr && reg_hit(paddr, AUXILIARY_CONTROL_TWO_ADDR))
      auxiliary_control_two_nxt = pwdata[7:0] & AUXILIARY_CONTROL_TWO_WMASK;
    if (wr && reg_hit(paddr, IRQ_EN_ADDR))
      irq_en_nxt = {8'h00, pwdata[P1_MASK_LSB +: 8], 4'h0,
        pwdata[NUM_SRC-1:0]};
  end

  // Clock gate levels are registered so they never glitch on a decode.
  always_comb
  begin
    cpu_on_nxt = (mode_nxt == MODE_RUN); // RQ3
    periph_on_nxt = (mode_nxt == MODE_RUN) || ((mode_nxt == MODE_IDLE)
      && !csc_nxt[CSC_PERIPH_GATE_BIT]); // RQ4
    t3_on_nxt = (mode_nxt == MODE_RUN) || (mode_nxt == MODE_IDLE)
      || ((mode_nxt == MODE_HALT) && timer3_enable); // RQ9
    wdt_on_nxt = wdt_enable; // RQ7
    fast_on_nxt = !csc_nxt[CSC_FAST_STOP_BIT] // RQ18
      && ((mode_nxt == MODE_RUN) || (mode_nxt == MODE_IDLE));
    slow_on_nxt = (mode_nxt == MODE_RUN) || (mode_nxt == MODE_IDLE)
      || ((mode_nxt == MODE_HALT) && (timer3_enable || wdt_enable));
    irq_nxt = |(flag_nxt & irq_en_nxt[NUM_SRC-1:0]);
    wake_nxt = (mode_r != MODE_RUN) && (mode_nxt == MODE_RUN);
  end

  // Read data is captured in the setup phase so it leaves a flop.
  always_comb
  begin
    prdata_nxt = prdata;
    pslverr_nxt = pslverr;
    if (setup)
    begin
      pslverr_nxt = 1'b0;
      if (reg_hit(paddr, PMC_ADDR))
        prdata_nxt = {24'h000000, pmc_r};
      else if (reg_hit(paddr, CSC_ADDR))
        prdata_nxt = {24'h000000, csc_r};
      else if (reg_hit(paddr, AUXILIARY_CONTROL_TWO_ADDR))
        prdata_nxt = {24'h000000, auxiliary_control_two_r};
      else if (reg_hit(paddr, IRQ_EN_ADDR))
        prdata_nxt = irq_en_r;
      else if (reg_hit(paddr, IRQ_FLAG_ADDR))
        prdata_nxt = {20'h00000, flag_r};
      else
      begin
        prdata_nxt = 32'h00000000;
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= MODE_RUN;
      pmc_r <= PMC_RESET;
      csc_r <= CSC_RESET;
      auxiliary_control_two_r <= AUXILIARY_CONTROL_TWO_RESET;
      irq_en_r <= 32'h00000000;
      flag_r <= '0;
      sync1_r <= 11'h7FF;
      sync2_r <= 11'h7FF;
      prev_r <= 11'h7FF;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      cpu_clock_on <= 1'b1;
      periph_clock_on <= 1'b1;
      timer3_clock_on <= 1'b1;
      wdt_clock_on <= 1'b0;
      fast_osc_on <= 1'b1;
      slow_osc_on <= 1'b1;
      irq_pending <= 1'b0;
      wake_pulse <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      pmc_r <= pmc_nxt;
      csc_r <= csc_nxt;
      auxiliary_control_two_r <= auxiliary_control_two_nxt;
      irq_en_r <= irq_en_nxt;
      flag_r <= flag_nxt;
      sync1_r <= {port1_pin, ext_int_n};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      prdata <= prdata_nxt;
      pslverr <= pslverr_nxt;
      cpu_clock_on <= cpu_on_nxt;
      periph_clock_on <= periph_on_nxt;
      timer3_clock_on <= t3_on_nxt;
      wdt_clock_on <= wdt_on_nxt;
      fast_osc_on <= fast_on_nxt;
      slow_osc_on <= slow_on_nxt;
      irq_pending <= irq_nxt;
      wake_pulse <= wake_nxt;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence idle_write_s;
    pmc_wr && pwdata[PMC_IDLE_BIT] && !pwdata[PMC_PD_BIT];
  endsequence
  sequence back_to_run_s;
    mode_r == MODE_RUN && pmc_r[PMC_PD_BIT:PMC_IDLE_BIT] == 2'h0
      && wake_pulse;
  endsequence

  chk_idle_entry: assert property ( // RQ2
    idle_write_s |=> mode_r == MODE_IDLE && !cpu_clock_on)
    else $error("Idle request did not stop the core.");

  chk_idle_wake_clear: assert property ( // RQ5
    (mode_r == MODE_IDLE && idle_wake) |=> back_to_run_s)
    else $error("Idle did not end on an enabled interrupt.");

  chk_idle_gating: assert property ( // RQ4
    mode_r == MODE_IDLE |-> timer3_clock_on
      && periph_clock_on == !csc_r[CSC_PERIPH_GATE_BIT])
    else $error("Idle peripheral gating wrong.");

  chk_stop_refused: assert property ( // RQ11
    (pmc_wr && pwdata[PMC_PD_BIT] && csc_r[CSC_SLOW_STOP_BIT]
      && stop_refused) |=> mode_r == MODE_RUN && !pmc_r[PMC_PD_BIT])
    else $error("Stop entered with an enabled pin low.");

  chk_stop_clocks: assert property ( // RQ7
    mode_r == MODE_STOP |-> !slow_osc_on && !fast_osc_on
      && !timer3_clock_on && !periph_clock_on)
    else $error("Clock left running in Stop.");

  chk_stop_hold: assert property ( // RQ8
    (mode_r == MODE_STOP && !stop_wake) |=> mode_r == MODE_STOP)
    else $error("Stop left without a pin wake.");

  chk_halt_wake: assert property ( // RQ10
    (mode_r == MODE_HALT && halt_wake) |=> back_to_run_s)
    else $error("Halt did not end on its wake source.");

  chk_flag_set: assert property ( // RQ14
    periph_event[SRC_TIMER0] |=> flag_r[SRC_TIMER0])
    else $error("Event did not set its flag.");

  chk_select_locked: assert property ( // RQ19
    (wr && reg_hit(paddr, CSC_ADDR) && csc_r[CSC_FAST_STOP_BIT])
      |=> $stable(csc_r[CSC_FAST_SEL_BIT]))
    else $error("Source select changed while fast clock stopped.");

endmodule : power_mode_clock_control

// File: hw/power_mode_clock_pkg.sv
// Shared constants and types for the power mode and clock controller.
// Assumes APB byte addressing with one 32-bit word per register index.
package power_mode_clock_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] PMC_IDX = 8'h87;
  localparam logic [7:0] CSC_IDX = 8'hD8;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_IDX = 8'hF7;
  localparam logic [ADDR_W-1:0] PMC_ADDR = {2'h0, PMC_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CSC_ADDR = {2'h0, CSC_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] AUXILIARY_CONTROL_TWO_ADDR = {2'h0, AUXILIARY_CONTROL_TWO_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 12'h400;
  localparam logic [ADDR_W-1:0] IRQ_FLAG_ADDR = 12'h404;

  // power_mode_control fields.
  localparam int unsigned PMC_IDLE_BIT = 0;
  localparam int unsigned PMC_PD_BIT = 1;
  localparam logic [7:0] PMC_RESET = 8'h00;
  localparam logic [7:0] PMC_WMASK = 8'h8F;

  // clock_source_config fields.
  localparam int unsigned CSC_SLOW_TYPE_BIT = 7;
  localparam int unsigned CSC_FAST_TYPE_BIT = 6;
  localparam int unsigned CSC_SLOW_STOP_BIT = 5;
  localparam int unsigned CSC_PERIPH_GATE_BIT = 4;
  localparam int unsigned CSC_FAST_STOP_BIT = 3;
  localparam int unsigned CSC_FAST_SEL_BIT = 2;
  localparam int unsigned CSC_DIV_LSB = 0;
  localparam logic [7:0] CSC_RESET = 8'h23;

  // auxiliary_control_two fields; bit 3 is reserved and reads zero.
  localparam int unsigned AUXILIARY_CONTROL_TWO_BANDGAP_BIT = 4;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_RESET = 8'h06;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_WMASK = 8'hF7;

  // Interrupt sources, in flag and enable bit order.
  localparam int unsigned NUM_SRC = 12;
  localparam int unsigned SRC_INT0 = 0;
  localparam int unsigned SRC_TIMER0 = 1;
  localparam int unsigned SRC_INT1 = 2;
  localparam int unsigned SRC_TIMER1 = 3;
  localparam int unsigned SRC_UART1 = 4;
  localparam int unsigned SRC_TIMER2 = 5;
  localparam int unsigned SRC_TIMER3 = 6;
  localparam int unsigned SRC_PORT1 = 7;
  localparam int unsigned SRC_INT2 = 8;
  localparam int unsigned SRC_ADC = 9;
  localparam int unsigned SRC_SPI = 10;
  localparam int unsigned SRC_UART2 = 11;
  localparam int unsigned P1_MASK_LSB = 16;

  // System clock divider codes and settle bound in clock cycles.
  localparam logic [1:0] DIV_16 = 2'h0;
  localparam logic [1:0] DIV_4 = 2'h1;
  localparam logic [1:0] DIV_2 = 2'h2;
  localparam logic [1:0] DIV_1 = 2'h3;
  localparam int unsigned DIV_SETTLE_CYC = 16;

  typedef enum logic [3:0] {
    MODE_RUN = 4'h1,
    MODE_IDLE = 4'h2,
    MODE_STOP = 4'h4,
    MODE_HALT = 4'h8
  } power_mode_t;

endpackage : power_mode_clock_pkg

// File: hw/system_clock_prescaler.sv
// System clock prescaler producing a one-cycle enable per divided period.
// Assumes the divider setting arrives from registers on the same clock.
`timescale 1ns/1ps
module system_clock_prescaler
  import power_mode_clock_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  clk_div_if.divider_end dv
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] mask;

  function automatic logic [3:0] div_mask(input logic [1:0] code);
    case (code)
      DIV_16: div_mask = 4'hF;
      DIV_4: div_mask = 4'h3;
      DIV_2: div_mask = 4'h1;
      default: div_mask = 4'h0;
    endcase
  endfunction : div_mask

  // A new code is used at once, which is well inside the settle bound.
  always_comb
  begin
    mask = div_mask(dv.divider);
    dv.tick = dv.run && ((cnt_r & mask) == mask); // RQ12
    cnt_nxt = dv.run ? cnt_r + 4'h1 : cnt_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_nxt;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_tick_within_bound: assert property ( // RQ12
    dv.run |-> ##[0:15] (dv.tick || !dv.run))
    else $error("Divided tick missing for sixteen cycles.");

  chk_div16_gap: assert property ( // RQ12
    (dv.tick && dv.divider == DIV_16) ##1 (dv.divider == DIV_16)
      |-> !dv.tick)
    else $error("Divide by sixteen ticked on adjacent cycles.");

endmodule : system_clock_prescaler

// File: verif/power_mode_clock_control_tb.sv
// Self-checking bench for the power mode and clock controller.
// Assumes the wake source model drives pins and event pulses.
`timescale 1ns/1ps
module power_mode_clock_control_tb;
  import power_mode_clock_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, wdt_enable, timer3_enable;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, cpu_clock_on, periph_clock_on;
  logic timer3_clock_on, wdt_clock_on, fast_osc_on, slow_osc_on;
  logic fast_clock_selected, fast_osc_type, slow_osc_type, sys_clk_tick;
  logic irq_pending, wake_pulse, bandgap_output_enable;
  logic [2:0] ext_int_n;
  logic [7:0] port1_pin;
  logic [11:0] periph_event;
  int bad_count, tests_run, cyc_count;
  int exp_tbl[4] = '{4, 16, 32, 64};

  power_mode_clock_control u_power_mode_clock_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_int_n, .port1_pin, .periph_event, .wdt_enable,
    .timer3_enable, .cpu_clock_on, .periph_clock_on, .timer3_clock_on,
    .wdt_clock_on, .fast_osc_on, .slow_osc_on, .fast_clock_selected,
    .fast_osc_type, .slow_osc_type, .sys_clk_tick, .irq_pending,
    .wake_pulse, .bandgap_output_enable
  );

  wake_source_model u_wake_source_model (
    .pclk, .ext_int_n, .port1_pin, .periph_event
  );

  always #50 pclk = ~pclk;

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // A hang in any wait ends here rather than running forever.
  always @(posedge pclk)
  begin
    cyc_count++;
    if (cyc_count == 5000)
    begin
      bad_count++;
      end_sim;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  task wake_wait;
    int i;
    for (i = 0; i < 20; i++)
    begin
      wt(1);
      if (wake_pulse === 1'b1)
        break;
    end
    chk({31'h0, wake_pulse}, 32'h1);
  endtask : wake_wait

  task clr;
    wt(4);
    apb(1'b1, IRQ_FLAG_ADDR, 32'hFFF);
  endtask : clr

  task t_reset;
    apb(1'b0, PMC_ADDR, 32'h0);
    chk(q, 32'h00);
    apb(1'b0, CSC_ADDR, 32'h0);
    chk(q, 32'h23);
    apb(1'b0, AUXILIARY_CONTROL_TWO_ADDR, 32'h0);
    chk(q, 32'h06);
    apb(1'b1, AUXILIARY_CONTROL_TWO_ADDR, 32'h1E);
    apb(1'b0, AUXILIARY_CONTROL_TWO_ADDR, 32'h0);
    chk(q, 32'h16);
    chk(bandgap_output_enable, 1'b1);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(e, 1'b1);
    chk(fast_clock_selected, 1'b0);
  endtask : t_reset

  task t_div;
    int c;
    int n;
    for (c = 0; c < 4; c++)
    begin
      apb(1'b1, CSC_ADDR, {24'h0, 6'h08, c[1:0]});
      wt(16);
      n = 0;
      repeat (64)
      begin
        wt(1);
        n += sys_clk_tick;
      end
      chk(n, exp_tbl[c]);
    end
  endtask : t_div

  task t_sel;
    apb(1'b1, CSC_ADDR, 32'h2B);
    wt(2);
    chk(fast_osc_on, 1'b0);
    apb(1'b1, CSC_ADDR, 32'h2F);
    apb(1'b0, CSC_ADDR, 32'h0);
    chk(q, 32'h2B);
    apb(1'b1, CSC_ADDR, 32'h23);
    apb(1'b1, CSC_ADDR, 32'h27);
    wt(1);
    chk(fast_clock_selected, 1'b1);
    apb(1'b1, CSC_ADDR, 32'hAF);
    apb(1'b0, CSC_ADDR, 32'h0);
    chk(q, 32'hA7);
    chk(slow_osc_type, 1'b1);
    apb(1'b1, CSC_ADDR, 32'h23);
    apb(1'b1, CSC_ADDR, 32'h63);
    wt(1);
    chk(fast_osc_type, 1'b1);
    chk(slow_osc_type, 1'b0);
    apb(1'b1, CSC_ADDR, 32'h23);
  endtask : t_sel

  task t_idle(input logic gate);
    apb(1'b1, CSC_ADDR, {24'h0, 3'h1, gate, 4'h3});
    apb(1'b1, IRQ_EN_ADDR, 32'h2);
    apb(1'b1, PMC_ADDR, 32'h1);
    wt(3);
    chk(cpu_clock_on, 1'b0);
    chk(periph_clock_on, !gate);
    chk(timer3_clock_on, 1'b1);
    u_wake_source_model.pulse(1);
    wake_wait;
    apb(1'b0, PMC_ADDR, 32'h0);
    chk(q & 32'h3, 32'h0);
    clr;
  endtask : t_idle

  task t_halt(input logic t3);
    timer3_enable <= t3;
    apb(1'b1, CSC_ADDR, 32'h03);
    apb(1'b1, IRQ_EN_ADDR, 32'h42);
    apb(1'b1, PMC_ADDR, 32'h2);
    wt(3);
    chk(cpu_clock_on, 1'b0);
    chk(periph_clock_on, 1'b0);
    chk(timer3_clock_on, t3);
    chk(slow_osc_on, t3 | wdt_enable);
    u_wake_source_model.pulse(1);
    wt(4);
    chk(cpu_clock_on, 1'b0);
    u_wake_source_model.pulse(6);
    wake_wait;
    clr;
  endtask : t_halt

  // Stop is entered twice, to wake once by a pin and once by Port1.
  task t_stop;
    int k;
    apb(1'b1, CSC_ADDR, 32'h23);
    apb(1'b1, IRQ_EN_ADDR, 32'h0001_0041);
    for (k = 0; k < 2; k++)
    begin
      wdt_enable <= k[0];
      apb(1'b1, PMC_ADDR, 32'h2);
      wt(3);
      chk(cpu_clock_on, 1'b0);
      chk(timer3_clock_on, 1'b0);
      chk(slow_osc_on, 1'b0);
      chk(wdt_clock_on, k[0]);
      u_wake_source_model.pulse(6);
      wt(4);
      chk(cpu_clock_on, 1'b0);
      if (k == 0)
        u_wake_source_model.pin(0, 1'b0);
      else
        u_wake_source_model.p1(8'hFE);
      wake_wait;
      u_wake_source_model.pin(0, 1'b1);
      u_wake_source_model.p1(8'hFF);
      clr;
    end
  endtask : t_stop

  task t_refuse;
    u_wake_source_model.pin(1, 1'b0);
    apb(1'b1, IRQ_EN_ADDR, 32'h4);
    wt(4);
    apb(1'b1, PMC_ADDR, 32'h2);
    wt(3);
    chk(cpu_clock_on, 1'b1);
    apb(1'b0, PMC_ADDR, 32'h0);
    chk(q, 32'h0);
    u_wake_source_model.pin(1, 1'b1);
    clr;
  endtask : t_refuse

  task t_flag;
    apb(1'b1, IRQ_EN_ADDR, 32'h0);
    u_wake_source_model.pulse(3);
    apb(1'b0, IRQ_FLAG_ADDR, 32'h0);
    chk(q, 32'h8);
    chk(irq_pending, 1'b0);
    apb(1'b1, IRQ_EN_ADDR, 32'h8);
    wt(1);
    chk(irq_pending, 1'b1);
    apb(1'b1, IRQ_FLAG_ADDR, 32'h8);
    apb(1'b0, IRQ_FLAG_ADDR, 32'h0);
    chk(q, 32'h0);
    chk(irq_pending, 1'b0);
  endtask : t_flag

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    wdt_enable = 1'b0;
    timer3_enable = 1'b0;
    bad_count = 0;
    tests_run = 0;
    cyc_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_div;
    t_sel;
    t_idle(1'b0);
    t_idle(1'b1);
    t_halt(1'b1);
    t_stop;
    t_refuse;
    t_flag;
    end_sim;
  end
endmodule : power_mode_clock_control_tb

// File: verif/wake_source_model.sv
// Model of the wake sources beside the core: pins and event pulses.
// Assumes pins idle high behind pull-ups and events last one pclk cycle.
`timescale 1ns/1ps
module wake_source_model (
  input wire logic pclk,
  output logic [2:0] ext_int_n,
  output logic [7:0] port1_pin,
  output logic [11:0] periph_event
);
  initial
  begin
    ext_int_n = 3'h7;
    port1_pin = 8'hFF;
    periph_event = 12'h000;
  end

  // Pulses last exactly one cycle, so a stuck source never re-wakes.
  task pulse(input int i);
    @(posedge pclk);
    periph_event <= 12'h001 << i;
    @(posedge pclk);
    periph_event <= 12'h000;
  endtask : pulse

  task pin(input int n, input logic v);
    @(posedge pclk);
    ext_int_n[n] <= v;
  endtask : pin

  task p1(input logic [7:0] v);
    @(posedge pclk);
    port1_pin <= v;
  endtask : p1
endmodule : wake_source_model
